// ### hdl/slc_pkg.sv
/*
 * constants of the switch link configuration and status block: register
 * indices, field positions, reset values, bus responses and state codes.
 * assumes a 32-bit AXI4-Lite register bus; byte address is four times index.
 */
// Summary of operation
// - status bits 25:24 report source target kind
// - bits 23:16 show destination link while busy
// - bits 5:4 select network, reset zero
// - bit 2 flags junk packet, packet discarded
// - bit 1 destination busy, bit 0 source busy
// - bit 31 enables link and steers pins
// - bit 30 selects five wire width
// - bit 27 flags overflow or illegal token
// - bit 26 shows credit granted to remote
// - bit 25 shows transmit credit; send waits
// - bit 24 clears credit, sends greeting
// - bit 23 resets receiver token framing
// - symbol gap: field 21:11 plus one
// - token gap: field 10:0 plus one
// - static enable bypasses routing to endpoint
// - static registers map to links C,D,A,B,G,H,E,F
// - static bit 8 selects destination processor
// - static bits 4:0 select channel end
// - one link configuration register per link 0..7
package slc_pkg;

    // ------------------------------------------------------------------
    // register map (indices; byte address = index * 4)
    // ------------------------------------------------------------------
    localparam int        NUM_LINKS    = 8;
    localparam int        ADDR_W       = 10;
    localparam logic [7:0] PL_BASE_IDX = 8'h40;
    localparam logic [7:0] XL_BASE_IDX = 8'h80;
    localparam logic [7:0] ST_BASE_IDX = 8'hA0;

    // ------------------------------------------------------------------
    // processor link status fields
    // ------------------------------------------------------------------
    localparam int         PL_KIND_LSB   = 24;
    localparam int         PL_DEST_LSB   = 16;
    localparam int         PL_NET_LSB    = 4;
    localparam int         PL_JUNK_BIT   = 2;
    localparam int         PL_DBUSY_BIT  = 1;
    localparam int         PL_SBUSY_BIT  = 0;
    localparam logic [1:0] PL_NET_RST    = 2'h0;

    // ------------------------------------------------------------------
    // external link configuration fields
    // ------------------------------------------------------------------
    localparam int          XL_EN_BIT      = 31;
    localparam int          XL_WIDE_BIT    = 30;
    localparam int          XL_RXERR_BIT   = 27;
    localparam int          XL_RXCRED_BIT  = 26;
    localparam int          XL_TXCRED_BIT  = 25;
    localparam int          XL_HELLO_BIT   = 24;
    localparam int          XL_RXRST_BIT   = 23;
    localparam int          XL_SYMGAP_LSB  = 11;
    localparam int          XL_TOKGAP_LSB  = 0;
    localparam int          GAP_W          = 11;
    localparam logic        XL_EN_RST      = 1'b0;
    localparam logic        XL_WIDE_RST    = 1'b0;
    localparam logic [10:0] XL_GAP_RST     = 11'h000;

    // ------------------------------------------------------------------
    // static forwarding fields
    // ------------------------------------------------------------------
    localparam int         ST_EN_BIT    = 31;
    localparam int         ST_PROC_BIT  = 8;
    localparam int         ST_END_LSB   = 0;
    localparam int         ST_END_W     = 5;
    localparam logic [4:0] ST_END_RST   = 5'h00;

    // ------------------------------------------------------------------
    // bus responses and decode regions
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        REG_NONE   = 2'b00,
        REG_STATUS = 2'b01,
        REG_CONFIG = 2'b10,
        REG_STATIC = 2'b11
    } slc_region_e;

    typedef enum logic {
        TX_READY = 1'b0,
        TX_WAIT  = 1'b1
    } slc_tx_e;

endpackage

// ### hdl/slc_top.sv
/*
 * switch link configuration and status: AXI4-Lite register slave holding
 * processor link status, external link configuration with a paced symbol
 * transmitter, and static forwarding configuration for eight links.
 * assumes all link-side inputs come from logic on aclk, pulses one cycle.
 */
`timescale 1ns/10ps
module slc_top #(
    parameter int NL = 8
) (
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // axi4-lite write address and data
    input  wire logic [9:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [9:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // processor link state from the switch
    input  wire logic [NL-1:0][1:0]   pl_source_target_kind,
    input  wire logic [NL-1:0][7:0]   pl_dest_link,
    input  wire logic [NL-1:0]        pl_junk,
    input  wire logic [NL-1:0]        pl_dest_busy,
    input  wire logic [NL-1:0]        pl_src_busy,
    // processor link controls
    output logic [NL-1:0][1:0]        pl_network,
    output logic [NL-1:0]             pl_discard,
    // external link events from the link engines
    input  wire logic [NL-1:0]        xl_sym_valid,
    input  wire logic [NL-1:0]        xl_sym_last,
    input  wire logic [NL-1:0]        xl_credit_in,
    input  wire logic [NL-1:0]        xl_credit_issued,
    input  wire logic [NL-1:0]        xl_rx_overflow,
    input  wire logic [NL-1:0]        xl_rx_illegal,
    // external link controls
    output logic [NL-1:0]             xl_enable,
    output logic [NL-1:0]             five_wire_select,
    output logic [NL-1:0]             greeting_trigger,
    output logic [NL-1:0]             xl_rx_reset,
    output logic [NL-1:0]             xl_sym_take,
    // static forwarding controls, indexed by link letter a..h
    output logic [NL-1:0]             st_bypass_routing,
    output logic [NL-1:0]             st_dest_processor,
    output logic [NL-1:0][4:0]        fixed_forward_endpoint
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // region of a register index
    function automatic slc_pkg::slc_region_e region_of(input logic [9:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (idx[7:3] == slc_pkg::PL_BASE_IDX[7:3]) begin
            return slc_pkg::REG_STATUS;
        end else if (idx[7:3] == slc_pkg::XL_BASE_IDX[7:3]) begin
            return slc_pkg::REG_CONFIG;
        end else if (idx[7:3] == slc_pkg::ST_BASE_IDX[7:3]) begin
            return slc_pkg::REG_STATIC;
        end else begin
            return slc_pkg::REG_NONE;
        end
    endfunction

    // static register slot to link letter (a=0 .. h=7)
    function automatic logic [2:0] static_link(input logic [2:0] slot);
        logic [2:0] lnk;
        lnk = {slot[2], ~slot[1], slot[0]};
        return lnk;
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // write channel handling
    // ------------------------------------------------------------------
    logic                aw_have_reg;
    logic                w_have_reg;
    logic [9:0]          awaddr_reg;
    logic [31:0]         wdata_reg;
    logic [3:0]          wstrb_reg;
    logic                aw_have_next;
    logic                w_have_next;
    logic                bvalid_next;
    logic                commit;
    logic [2:0]          wlink;
    slc_pkg::slc_region_e wregion;

    assign commit  = aw_have_reg & w_have_reg & ~s_axi_bvalid;
    assign wlink   = awaddr_reg[4:2];
    assign wregion = region_of(awaddr_reg);

    // next values of the write handshake state
    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next  = w_have_reg;
        bvalid_next  = s_axi_bvalid;
        if (s_axi_awvalid & s_axi_awready) begin
            aw_have_next = 1'b1;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_have_next = 1'b1;
        end
        if (commit) begin
            aw_have_next = 1'b0;
            w_have_next  = 1'b0;
            bvalid_next  = 1'b1;
        end else if (s_axi_bvalid & s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // address and data are taken in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            awaddr_reg    <= 10'h000;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= slc_pkg::RESP_OKAY;
        end else begin
            aw_have_reg   <= aw_have_next;
            w_have_reg    <= w_have_next;
            s_axi_awready <= ~aw_have_next & ~bvalid_next;
            s_axi_wready  <= ~w_have_next & ~bvalid_next;
            s_axi_bvalid  <= bvalid_next;
            if (s_axi_awvalid & s_axi_awready) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (commit) begin
                s_axi_bresp <= (wregion == slc_pkg::REG_NONE) ? slc_pkg::RESP_SLVERR
                                                              : slc_pkg::RESP_OKAY;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------------
    logic [NL-1:0][10:0] symgap_reg;
    logic [NL-1:0][10:0] tokgap_reg;
    logic [31:0]         wmerged;

    // gap fields of the addressed slot with the strobed lanes written over them
    always_comb begin
        wmerged = merge({10'h000, symgap_reg[wlink], tokgap_reg[wlink]}, wdata_reg, wstrb_reg);
    end

    // processor link network field
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NL; i++) begin
                pl_network[i] <= slc_pkg::PL_NET_RST;
            end
        end else if (commit && wregion == slc_pkg::REG_STATUS && wstrb_reg[0]) begin
            pl_network[wlink] <= wdata_reg[slc_pkg::PL_NET_LSB +: 2];
        end
    end

    // external link enable, width and gap fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NL; i++) begin
                xl_enable[i]        <= slc_pkg::XL_EN_RST;
                five_wire_select[i] <= slc_pkg::XL_WIDE_RST;
                symgap_reg[i]       <= slc_pkg::XL_GAP_RST;
                tokgap_reg[i]       <= slc_pkg::XL_GAP_RST;
            end
        end else if (commit && wregion == slc_pkg::REG_CONFIG) begin
            if (wstrb_reg[3]) begin
                xl_enable[wlink]        <= wdata_reg[slc_pkg::XL_EN_BIT];
                five_wire_select[wlink] <= wdata_reg[slc_pkg::XL_WIDE_BIT];
            end
            symgap_reg[wlink] <= wmerged[slc_pkg::XL_SYMGAP_LSB +: slc_pkg::GAP_W];
            tokgap_reg[wlink] <= wmerged[slc_pkg::XL_TOKGAP_LSB +: slc_pkg::GAP_W];
        end
    end

    // static forwarding fields, stored by link letter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NL; i++) begin
                st_bypass_routing[i]      <= 1'b0;
                st_dest_processor[i]      <= 1'b0;
                fixed_forward_endpoint[i] <= slc_pkg::ST_END_RST;
            end
        end else if (commit && wregion == slc_pkg::REG_STATIC) begin
            if (wstrb_reg[3]) begin
                st_bypass_routing[static_link(wlink)] <= wdata_reg[slc_pkg::ST_EN_BIT];
            end
            if (wstrb_reg[1]) begin
                st_dest_processor[static_link(wlink)] <= wdata_reg[slc_pkg::ST_PROC_BIT];
            end
            if (wstrb_reg[0]) begin
                fixed_forward_endpoint[static_link(wlink)] <=
                    wdata_reg[slc_pkg::ST_END_LSB +: slc_pkg::ST_END_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // write-only triggers and link status flags
    // ------------------------------------------------------------------
    logic [NL-1:0] hello_wr;
    logic [NL-1:0] rxrst_wr;
    logic [NL-1:0] tx_credit_reg;
    logic [NL-1:0] rx_credit_reg;
    logic [NL-1:0] rx_error_reg;

    // trigger decode, only during the write commit cycle
    always_comb begin
        for (int i = 0; i < NL; i++) begin
            hello_wr[i] = commit && wregion == slc_pkg::REG_CONFIG && wlink == i[2:0] &&
                          wstrb_reg[3] && wdata_reg[slc_pkg::XL_HELLO_BIT];
            rxrst_wr[i] = commit && wregion == slc_pkg::REG_CONFIG && wlink == i[2:0] &&
                          wstrb_reg[2] && wdata_reg[slc_pkg::XL_RXRST_BIT];
        end
    end

    // one-cycle trigger pulses toward the link engines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            greeting_trigger <= '0;
            xl_rx_reset      <= '0;
        end else begin
            greeting_trigger <= hello_wr;
            xl_rx_reset      <= rxrst_wr;
        end
    end

    // sticky link flags; an arriving event wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_credit_reg <= '0;
            rx_credit_reg <= '0;
            rx_error_reg  <= '0;
        end else begin
            tx_credit_reg <= (tx_credit_reg & ~hello_wr) | xl_credit_in;
            rx_credit_reg <= (rx_credit_reg & ~rxrst_wr) | xl_credit_issued;
            rx_error_reg  <= (rx_error_reg & ~rxrst_wr) | xl_rx_overflow | xl_rx_illegal;
        end
    end

    // junk packets are dropped by the switch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pl_discard <= '0;
        end else begin
            pl_discard <= pl_junk;
        end
    end

    // ------------------------------------------------------------------
    // paced symbol transmitter, one per external link
    // ------------------------------------------------------------------
    slc_pkg::slc_tx_e    tx_state_reg [NL];
    logic [NL-1:0][10:0] gap_cnt_reg;

    // a symbol is taken only with credit, then the gap is counted out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xl_sym_take <= '0;
            for (int i = 0; i < NL; i++) begin
                tx_state_reg[i] <= slc_pkg::TX_READY;
                gap_cnt_reg[i]  <= 11'h000;
            end
        end else begin
            for (int i = 0; i < NL; i++) begin
                xl_sym_take[i] <= 1'b0;
                case (tx_state_reg[i])
                    slc_pkg::TX_READY: begin
                        if (xl_sym_valid[i] && tx_credit_reg[i] && xl_enable[i]) begin
                            xl_sym_take[i]  <= 1'b1;
                            tx_state_reg[i] <= slc_pkg::TX_WAIT;
                            gap_cnt_reg[i]  <= xl_sym_last[i] ? tokgap_reg[i]
                                                              : symgap_reg[i];
                        end
                    end
                    slc_pkg::TX_WAIT: begin
                        if (gap_cnt_reg[i] == 11'h000) begin
                            tx_state_reg[i] <= slc_pkg::TX_READY;
                        end else begin
                            gap_cnt_reg[i] <= gap_cnt_reg[i] - 11'h001;
                        end
                    end
                    default: begin
                        tx_state_reg[i] <= slc_pkg::TX_READY;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    logic [31:0]          rword;
    logic [2:0]           rlink;
    slc_pkg::slc_region_e rregion;
    logic                 rvalid_next;

    assign rlink       = s_axi_araddr[4:2];
    assign rregion     = region_of(s_axi_araddr);
    assign rvalid_next = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);

    // read word assembly; reserved and trigger bits read zero
    always_comb begin
        rword = 32'h0000_0000;
        if (rregion == slc_pkg::REG_STATUS) begin
            rword[slc_pkg::PL_KIND_LSB +: 2] = pl_source_target_kind[rlink];
            if (pl_src_busy[rlink] | pl_dest_busy[rlink]) begin
                rword[slc_pkg::PL_DEST_LSB +: 8] = pl_dest_link[rlink];
            end
            rword[slc_pkg::PL_NET_LSB +: 2]   = pl_network[rlink];
            rword[slc_pkg::PL_JUNK_BIT]       = pl_junk[rlink];
            rword[slc_pkg::PL_DBUSY_BIT]      = pl_dest_busy[rlink];
            rword[slc_pkg::PL_SBUSY_BIT]      = pl_src_busy[rlink];
        end else if (rregion == slc_pkg::REG_CONFIG) begin
            rword[slc_pkg::XL_EN_BIT]                 = xl_enable[rlink];
            rword[slc_pkg::XL_WIDE_BIT]               = five_wire_select[rlink];
            rword[slc_pkg::XL_RXERR_BIT]              = rx_error_reg[rlink];
            rword[slc_pkg::XL_RXCRED_BIT]             = rx_credit_reg[rlink];
            rword[slc_pkg::XL_TXCRED_BIT]             = tx_credit_reg[rlink];
            rword[slc_pkg::XL_SYMGAP_LSB +: slc_pkg::GAP_W] = symgap_reg[rlink];
            rword[slc_pkg::XL_TOKGAP_LSB +: slc_pkg::GAP_W] = tokgap_reg[rlink];
        end else if (rregion == slc_pkg::REG_STATIC) begin
            rword[slc_pkg::ST_EN_BIT]   = st_bypass_routing[static_link(rlink)];
            rword[slc_pkg::ST_PROC_BIT] = st_dest_processor[static_link(rlink)];
            rword[slc_pkg::ST_END_LSB +: slc_pkg::ST_END_W] =
                fixed_forward_endpoint[static_link(rlink)];
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= slc_pkg::RESP_OKAY;
        end else begin
            s_axi_rvalid  <= rvalid_next;
            s_axi_arready <= ~rvalid_next;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rdata <= rword;
                s_axi_rresp <= (rregion == slc_pkg::REG_NONE) ? slc_pkg::RESP_SLVERR
                                                              : slc_pkg::RESP_OKAY;
            end
        end
    end

endmodule

// ### sim/slc_link_model.sv
/* far-end link engine model for link 0: counted symbols, credit on greeting
   assumes it shares aclk and aresetn with the block */
`timescale 1ns/10ps
module slc_link_model (
    // clock, reset, load
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] load,
    // link side
    input  wire logic       greet,
    input  wire logic       take,
    output logic            valid,
    output logic            last,
    output logic            credit
);
    logic [2:0] left_reg;
    // symbol pool, retired on take, odd remainder ends a token
    always_ff @(posedge aclk) begin
        if (!aresetn) left_reg <= 3'h0;
        else if (load != 3'h0) left_reg <= load;
        else if (take) left_reg <= left_reg - 3'h1;
    end
    assign valid = left_reg != 3'h0;
    assign last  = left_reg[0];
    // credit granted the cycle after a greeting
    always_ff @(posedge aclk) credit <= aresetn && greet;
endmodule

// ### sim/slc_top_sva.sv
/* checker on the top ports of slc_top
   assumes one clock aclk and synchronous active-low aresetn */
`timescale 1ns/10ps
module slc_top_sva #(
    parameter int NL = 8
) (
    // clock, reset, bus
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire logic          s_axi_arvalid,
    input wire logic          s_axi_arready,
    input wire logic          s_axi_rvalid,
    input wire logic          s_axi_bvalid,
    input wire logic          s_axi_bready,
    // link side
    input wire logic [NL-1:0] pl_junk,
    input wire logic [NL-1:0] pl_discard,
    input wire logic [NL-1:0] xl_enable,
    input wire logic [NL-1:0] xl_sym_valid,
    input wire logic [NL-1:0] xl_sym_take,
    input wire logic [NL-1:0] greeting_trigger,
    input wire logic [NL-1:0] xl_rx_reset
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // triggers, pacing, discard and bus answers
    greet_pulse_a:
    assert property (greeting_trigger[0] |=> !greeting_trigger[0]) else $error("greet held");
    rx_reset_pulse_a:
    assert property (xl_rx_reset[0] |=> !xl_rx_reset[0]) else $error("rx reset held");
    junk_discard_a:
    assert property (pl_junk[0] |=> pl_discard[0]) else $error("junk kept");
    take_gap_a:
    assert property (xl_sym_take[0] |=> !xl_sym_take[0]) else $error("take too close");
    take_cause_a:
    assert property (xl_sym_take[0] |-> $past(xl_enable[0]) && $past(xl_sym_valid[0]))
        else $error("take without cause");
    read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
    read_block_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready early");
    write_done_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
endmodule
bind slc_top slc_top_sva #(.NL(NL)) slc_top_sva_i (.*);

// ### sim/slc_top_tb_top.sv
/* bench for slc_top: axi4-lite master tasks, row table, link 0 model
   assumes a 40 MHz aclk; links 1..7 stay idle */
`timescale 1ns/10ps
module slc_top_tb_top;
    `define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
        $display("mismatch %s exp %h seen %h", n, e, g); end end
    typedef struct packed {logic [9:0] a; logic [31:0] w, e; logic [1:0] r;} slc_row_s;
    logic            aclk = 1'b0, aresetn = 1'b0, mv, ml, mc;
    logic [9:0]      s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0]     s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]      s_axi_wstrb = 4'hF;
    logic [2:0]      ld = 3'h0;
    logic [1:0]      s_axi_bresp, s_axi_rresp, r;
    logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic            s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic            s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0][1:0] pl_source_target_kind = 16'h00C6, pl_network;
    logic [7:0][7:0] pl_dest_link = {8{8'h5A}};
    logic [7:0][4:0] fixed_forward_endpoint;
    logic [7:0]      pl_junk = 8'h01, pl_dest_busy = 8'h01, pl_src_busy = 8'h02, pl_discard;
    logic [7:0]      xl_credit_issued = 8'h00, xl_rx_overflow = 8'h00, xl_rx_illegal = 8'h00;
    logic [7:0]      xl_sym_valid, xl_sym_last, xl_credit_in, xl_enable, five_wire_select;
    logic [7:0]      greeting_trigger, xl_rx_reset, xl_sym_take;
    logic [7:0]      st_bypass_routing, st_dest_processor;
    int              error_cnt = 0, checked = 0, cyc = 0, tk[$];
    int              smap[8] = '{2, 3, 0, 1, 6, 7, 4, 5};
    slc_row_s        rows[6] = '{'{10'h100, 32'hFFFFFFFF, 32'h025A0036, 2'h0},
        '{10'h104, 32'h00000000, 32'h015A0001, 2'h0}, '{10'h108, 32'h20, 32'h20, 2'h0},
        '{10'h10C, 32'h00000010, 32'h03000010, 2'h0},
        '{10'h21C, 32'h407FFFFF, 32'h403FFFFF, 2'h0},
        '{10'h220, 32'hFFFFFFFF, 32'h00000000, 2'h2}};
    // clock, link 0 wiring, instances
    always #12.5 aclk = ~aclk;
    assign xl_sym_valid = {7'h00, mv};
    assign xl_sym_last  = {7'h00, ml};
    assign xl_credit_in = {7'h00, mc};
    slc_top slc_top_i (.*);
    slc_link_model slc_link_model_i (.aclk(aclk), .aresetn(aresetn), .load(ld),
        .greet(greeting_trigger[0]), .take(xl_sym_take[0]), .valid(mv), .last(ml), .credit(mc));
    // cycle count, take times, hang limit
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (xl_sym_take[0]) tk.push_back(cyc);
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish;
        end
    end
    // one write: address and data released as each is taken
    task automatic wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w;
        @(posedge aclk);
        {aw, w} = 2'b00;
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && !w) s_axi_wvalid <= 1'b0;
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // one read
    task automatic rd(input logic [9:0] a, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // counts and verdict
    task automatic tally_and_finish;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(10'h200, d);
        `CHK("cfg reset", 32'h0, d)
        rd(10'h280, d);
        `CHK("static reset", 32'h0, d)
        $display("reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w, r);
            `CHK("bresp", rows[i].r, r)
            rd(rows[i].a, d);
            `CHK("rdata", {rows[i].r, rows[i].e}, {r, d})
        end
        $display("rows done");
        foreach (smap[s]) begin
            wr(10'(10'h280 + 4 * s), 32'h80000100 | s, r);
            `CHK("endpoint", 5'(s), fixed_forward_endpoint[smap[s]])
        end
        `CHK("bypass", 16'hFF01, {st_bypass_routing, pl_discard})
        `CHK("processor", 8'hFF, st_dest_processor)
        $display("static done");
        wr(10'h200, 32'hC1002803, r);
        `CHK("enable", 4'hF, {xl_enable[0], five_wire_select[0], pl_network[0]})
        repeat (3) @(posedge aclk);
        rd(10'h200, d);
        `CHK("credit", 32'hC2002803, d)
        ld <= 3'h4;
        @(posedge aclk);
        ld <= 3'h0;
        repeat (40) @(posedge aclk);
        for (int i = 0; i < 3; i++) `CHK("gap", (i % 2) ? 5 : 7, tk[i + 1] - tk[i])
        $display("transmit done");
        {xl_rx_overflow, xl_credit_issued} <= 16'h0101;
        @(posedge aclk);
        {xl_rx_overflow, xl_credit_issued} <= 16'h0000;
        rd(10'h200, d);
        `CHK("rx flags", 32'hCE002803, d)
        wr(10'h200, 32'hC0802803, r);
        xl_rx_illegal <= 8'h01;
        @(posedge aclk);
        xl_rx_illegal <= 8'h00;
        rd(10'h200, d);
        `CHK("rx reset", 32'hCA002803, d)
        wr(10'h200, 32'h0, r);
        `CHK("disable", 1'b0, xl_enable[0])
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(10'h200, d);
        `CHK("mid reset", 32'h0, d)
        $display("receive and reset done");
        tally_and_finish;
    end
endmodule
